// ===== dprm_core.v
// realignment sequencer, loop readout select, reference compare setup
// assumes loop values and monitor counts come from logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "dprm_defs.vh"
module dprm_core #(
	parameter NIN       = `DPRM_NUM_INPUTS,
	parameter RAMP_STEP = 16,
	parameter DIV_CYC   = 8
) (
	input  wire                 clk,
	input  wire                 reset_n,
	input  wire [7:0]           addr,
	input  wire [7:0]           wdata,
	input  wire                 wstrobe,
	input  wire                 rstrobe,
	output reg  [7:0]           rdata,
	input  wire signed [23:0]   primary_integral,
	input  wire signed [23:0]   secondary_integral,
	input  wire signed [15:0]   primary_pd_error,
	input  wire signed [15:0]   secondary_pd_error,
	input  wire signed [15:0]   primary_ref_phase,
	input  wire signed [15:0]   secondary_ref_phase,
	input  wire [3:0]           secondary_auto_select,
	input  wire [NIN*8-1:0]     input_loop_frequency_readout_offset,
	output reg                  mini_holdover,
	output reg                  divider_reset,
	output reg signed [16:0]    applied_offset,
	output reg                  secondary_path_disable,
	output reg  [3:0]           secondary_select,
	output reg                  copy_divide,
	output reg                  copy_by_n,
	output reg  [1:0]           primary_lock_mode,
	output reg  [4:0]           primary_bandwidth,
	output reg  [1:0]           secondary_bandwidth,
	output reg  [NIN-1:0]       input_invalid
);
	// sequencer states
	localparam ST_IDLE  = 3'd0;
	localparam ST_ENTER = 3'd1;
	localparam ST_RZERO = 3'd2;
	localparam ST_RDIV  = 3'd3;
	localparam ST_RBACK = 3'd4;
	localparam ST_EXIT  = 3'd5;
	localparam signed [16:0] RAMP_W = RAMP_STEP[16:0]; // ramp step at offset width

	// software registers
	reg               realign_request;
	reg               readout_loop_select;
	reg               reference_compare_enable;
	reg  [3:0]        secondary_ref_force_select;
	reg  [15:0]       offset_reg;
	reg  [7:0]        bw_reg;
	reg  [7:0]        input_config;
	reg  [7:0]        input_loop_frequency_readout_limit;

	// sequencer
	reg  [2:0]        state;
	reg  [2:0]        next_state;
	reg  [7:0]        div_cnt;
	reg  signed [16:0] next_offset;

	// readout
	reg  signed [23:0] frq_live;
	reg  signed [23:0] frq_snap;
	reg  signed [15:0] phs_snap;
	wire signed [15:0] sec_phase_src;
	wire signed [15:0] pri_phase_avg;
	wire signed [15:0] sec_phase_avg;
	wire signed [15:0] phs_live;
	wire signed [16:0] ofs_target;
	wire               offset_write;

	// compare the magnitude of a signed byte with the limit
	function over_limit;
		input [7:0] value;
		input [7:0] limit;
		begin
			over_limit = ((value[7] ? (~value + 8'h01) : value) > limit);
		end
	endfunction

	// clamp programmed offset to +/-200 ns in 6 ps steps
	function signed [16:0] clamp_ofs;
		input [15:0] raw;
		reg signed [16:0] ext;
		begin
			ext = {raw[15], raw};
			if (ext > `DPRM_OFS_MAX)
				clamp_ofs = `DPRM_OFS_MAX;
			else if (ext < -`DPRM_OFS_MAX)
				clamp_ofs = -`DPRM_OFS_MAX;
			else
				clamp_ofs = ext;
		end
	endfunction

	assign ofs_target   = clamp_ofs(offset_reg);
	assign offset_write = wstrobe &&
		((addr == `DPRM_ADDR_OFS_LO) || (addr == `DPRM_ADDR_OFS_HI));

	// register writes; realign bit clears itself when the sequence ends
	always @(posedge clk) begin
		if (!reset_n) begin
			realign_request            <= 1'b0;
			readout_loop_select        <= 1'b0;
			reference_compare_enable   <= 1'b0;
			secondary_ref_force_select <= 4'h0;
			offset_reg                 <= 16'h0000;
			bw_reg                     <= `DPRM_RST_BW;
			input_config               <= 8'h00;
			input_loop_frequency_readout_limit           <= `DPRM_RST_ILIM;
		end else begin
			if (wstrobe && addr == `DPRM_ADDR_FSC3 && wdata[`DPRM_BIT_REALIGN])
				realign_request <= 1'b1;
			else if (state == ST_EXIT)
				realign_request <= 1'b0;
			if (wstrobe) begin
				if (addr == `DPRM_ADDR_MC11)
					readout_loop_select <= wdata[`DPRM_BIT_LOOPSEL];
				else if (addr == `DPRM_ADDR_PLC1)
					reference_compare_enable <= wdata[`DPRM_BIT_CMPEN];
				else if (addr == `DPRM_ADDR_MC4)
					secondary_ref_force_select <= wdata[3:0];
				else if (addr == `DPRM_ADDR_OFS_LO)
					offset_reg[7:0] <= wdata;
				else if (addr == `DPRM_ADDR_OFS_HI)
					offset_reg[15:8] <= wdata;
				else if (addr == `DPRM_ADDR_BW)
					bw_reg <= wdata;
				else if (addr == `DPRM_ADDR_ICFG)
					input_config <= wdata;
				else if (addr == `DPRM_ADDR_ILIM)
					input_loop_frequency_readout_limit <= wdata;
			end
		end
	end

	// realignment sequence next state
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (realign_request)
					next_state = ST_ENTER;
			end
			ST_ENTER: begin
				next_state = ST_RZERO;
			end
			ST_RZERO: begin
				if (applied_offset == 17'sd0)
					next_state = ST_RDIV;
			end
			ST_RDIV: begin
				if (div_cnt == 8'h00)
					next_state = ST_RBACK;
			end
			ST_RBACK: begin
				if (applied_offset == ofs_target && !offset_write)
					next_state = ST_EXIT;
			end
			ST_EXIT: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// ramp one step toward the current goal
	always @* begin
		next_offset = applied_offset;
		if (state == ST_RZERO) begin
			if (applied_offset > RAMP_W)
				next_offset = applied_offset - RAMP_W;
			else if (applied_offset < -RAMP_W)
				next_offset = applied_offset + RAMP_W;
			else
				next_offset = 17'sd0;
		end else begin
			// idle and ramp back both step toward newest offset, RAMP_STEP per clock
			if (ofs_target > applied_offset + RAMP_W)
				next_offset = applied_offset + RAMP_W;
			else if (ofs_target < applied_offset - RAMP_W)
				next_offset = applied_offset - RAMP_W;
			else
				next_offset = ofs_target;
			if (state == ST_ENTER || state == ST_RDIV || state == ST_EXIT)
				next_offset = applied_offset;
		end
	end

	// sequencer registers and its outputs
	always @(posedge clk) begin
		if (!reset_n) begin
			state          <= ST_IDLE;
			div_cnt        <= 8'h00;
			applied_offset <= 17'sd0;
			mini_holdover  <= 1'b0;
			divider_reset  <= 1'b0;
		end else begin
			state          <= next_state;
			applied_offset <= next_offset;
			if (next_state == ST_RDIV && state != ST_RDIV)
				div_cnt <= DIV_CYC[7:0] - 8'h01;
			else if (div_cnt != 8'h00)
				div_cnt <= div_cnt - 8'h01;
			mini_holdover <= (next_state != ST_IDLE) &&
				(next_state != ST_EXIT);
			divider_reset <= (next_state == ST_RDIV);
		end
	end

	// secondary phase source: detector error, or reference against reference
	assign sec_phase_src = reference_compare_enable ?
		(primary_ref_phase - secondary_ref_phase) : secondary_pd_error;

	// phase averaging, one filter per loop
	dprm_avg_filter #(
		.WIDTH (16),
		.SHIFT (`DPRM_PHS_SHIFT)
	) u_pri_filt (
		.clk     (clk),
		.reset_n (reset_n),
		.sample  (primary_pd_error),
		.average (pri_phase_avg)
	);
	dprm_avg_filter #(
		.WIDTH (16),
		.SHIFT (`DPRM_PHS_SHIFT)
	) u_sec_filt (
		.clk     (clk),
		.reset_n (reset_n),
		.sample  (sec_phase_src),
		.average (sec_phase_avg)
	);

	// loop select for both readouts
	assign phs_live = readout_loop_select ? sec_phase_avg : pri_phase_avg;

	// frequency readout from the integral path, clamped to +/-80 ppm
	always @* begin
		frq_live = readout_loop_select ? secondary_integral : primary_integral;
		if (frq_live > `DPRM_FRQ_MAX)
			frq_live = `DPRM_FRQ_MAX;
		else if (frq_live < `DPRM_FRQ_MIN)
			frq_live = `DPRM_FRQ_MIN;
	end

	// loop configuration outputs
	always @(posedge clk) begin
		if (!reset_n) begin
			secondary_path_disable <= 1'b0;
			secondary_select       <= 4'h0;
			copy_divide            <= 1'b0;
			copy_by_n              <= 1'b0;
			primary_lock_mode      <= `DPRM_MODE_DIRECT;
			primary_bandwidth      <= 5'h00;
			secondary_bandwidth    <= 2'h0;
		end else begin
			secondary_path_disable <= reference_compare_enable;
			// nonzero force value overrides automatic choice
			secondary_select <= (secondary_ref_force_select != 4'h0) ?
				secondary_ref_force_select : secondary_auto_select;
			copy_divide <= reference_compare_enable &&
				(input_config[3:2] != `DPRM_MODE_DIRECT);
			copy_by_n <= (input_config[1:0] == `DPRM_MODE_BY_N);
			primary_lock_mode <= input_config[1:0];
			primary_bandwidth <= (bw_reg[4:0] > `DPRM_BW_PRI_MAX) ?
				`DPRM_BW_PRI_MAX : bw_reg[4:0];
			secondary_bandwidth <= (bw_reg[6:5] > `DPRM_BW_SEC_MAX) ?
				`DPRM_BW_SEC_MAX : bw_reg[6:5];
		end
	end

	// per-input validity against the programmed limit
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi = gi + 1) begin : g_mon
			always @(posedge clk) begin
				if (!reset_n)
					input_invalid[gi] <= 1'b0;
				else
					input_invalid[gi] <= over_limit(input_loop_frequency_readout_offset[gi*8+7:gi*8],
						input_loop_frequency_readout_limit);
			end
		end
	endgenerate

	// readout snapshots taken when the first byte is read
	always @(posedge clk) begin
		if (!reset_n) begin
			frq_snap <= 24'sh000000;
			phs_snap <= 16'sh0000;
		end else begin
			if (rstrobe && addr == `DPRM_ADDR_FRQ1)
				frq_snap <= frq_live;
			if (rstrobe && addr == `DPRM_ADDR_PHS1)
				phs_snap <= phs_live;
		end
	end

	// read data, one cycle after the read strobe, zero otherwise
	always @(posedge clk) begin
		if (!reset_n || !rstrobe)
			rdata <= 8'h00;
		else if (addr == `DPRM_ADDR_FSC3)
			rdata <= {7'h00, realign_request};
		else if (addr == `DPRM_ADDR_MC11)
			rdata <= {7'h00, readout_loop_select};
		else if (addr == `DPRM_ADDR_PLC1)
			rdata <= {7'h00, reference_compare_enable};
		else if (addr == `DPRM_ADDR_MC4)
			rdata <= {4'h0, secondary_ref_force_select};
		else if (addr == `DPRM_ADDR_OFS_LO)
			rdata <= offset_reg[7:0];
		else if (addr == `DPRM_ADDR_OFS_HI)
			rdata <= offset_reg[15:8];
		else if (addr == `DPRM_ADDR_BW)
			rdata <= bw_reg;
		else if (addr == `DPRM_ADDR_ICFG)
			rdata <= input_config;
		else if (addr == `DPRM_ADDR_ILIM)
			rdata <= input_loop_frequency_readout_limit;
		else if (addr == `DPRM_ADDR_FRQ1)
			rdata <= frq_live[7:0];
		else if (addr == `DPRM_ADDR_FRQ2)
			rdata <= frq_snap[15:8];
		else if (addr == `DPRM_ADDR_FRQ3)
			rdata <= frq_snap[23:16];
		else if (addr == `DPRM_ADDR_PHS1)
			rdata <= phs_live[7:0];
		else if (addr == `DPRM_ADDR_PHS2)
			rdata <= phs_snap[15:8];
		else if (addr == `DPRM_ADDR_STAT)
			rdata <= {4'h0, copy_by_n, copy_divide,
				mini_holdover, realign_request};
		else
			rdata <= 8'h00;
	end
endmodule
`default_nettype wire

// ===== dprm_defs.vh
// register map, field positions, reset values and limits of the dpll
// realignment and measurement block
// assumes an 8-bit register port and a 100 MHz system clock
`ifndef DPRM_DEFS_VH
`define DPRM_DEFS_VH

// register addresses
`define DPRM_ADDR_FSC3      8'h00
`define DPRM_ADDR_MC11      8'h01
`define DPRM_ADDR_PLC1      8'h02
`define DPRM_ADDR_MC4       8'h03
`define DPRM_ADDR_OFS_LO    8'h04
`define DPRM_ADDR_OFS_HI    8'h05
`define DPRM_ADDR_BW        8'h06
`define DPRM_ADDR_ICFG      8'h07
`define DPRM_ADDR_ILIM      8'h08
`define DPRM_ADDR_FRQ1      8'h10
`define DPRM_ADDR_FRQ2      8'h11
`define DPRM_ADDR_FRQ3      8'h12
`define DPRM_ADDR_PHS1      8'h13
`define DPRM_ADDR_PHS2      8'h14
`define DPRM_ADDR_STAT      8'h15

// field positions
`define DPRM_BIT_REALIGN    0
`define DPRM_BIT_LOOPSEL    0
`define DPRM_BIT_CMPEN      0

// locking modes of a reference input
`define DPRM_MODE_DIRECT    2'h0
`define DPRM_MODE_EDGE8K    2'h1
`define DPRM_MODE_BY_N      2'h2

// reset values
`define DPRM_RST_BW         8'h0A
`define DPRM_RST_ILIM       8'h20

// limits
`define DPRM_BW_PRI_MAX     5'h11
`define DPRM_BW_SEC_MAX     2'h2
`define DPRM_OFS_MAX        17'sh08235
`define DPRM_FRQ_MAX        24'sh03FA94
`define DPRM_FRQ_MIN        24'shFC056C
`define DPRM_NUM_INPUTS     14

// phase averaging: 2*pi*100 Hz / 100 MHz is close to 2^-17
`define DPRM_PHS_SHIFT      17

`endif

// ===== dprm_avg_filter.v
// first-order low-pass averaging filter for the phase readout
// assumes input samples arrive every clock on the same clock domain
`timescale 1ns/1ps
`default_nettype none
module dprm_avg_filter #(
	parameter WIDTH = 16,
	parameter SHIFT = 17
) (
	input  wire                    clk,
	input  wire                    reset_n,
	input  wire signed [WIDTH-1:0] sample,
	output wire signed [WIDTH-1:0] average
);
	localparam AW = WIDTH + SHIFT;

	reg  signed [AW-1:0] acc;
	wire signed [AW-1:0] sample_ext;
	wire signed [AW-1:0] next_acc;

	// sample scaled to accumulator precision
	assign sample_ext = {sample, {SHIFT{1'b0}}};
	// acc += (x - y) / 2^shift, a single pole near 100 Hz
	assign next_acc = acc + ((sample_ext - acc) >>> SHIFT);

	// accumulator register
	always @(posedge clk) begin
		if (!reset_n) begin
			acc <= {AW{1'b0}};
		end else begin
			acc <= next_acc;
		end
	end

	assign average = acc[AW-1:SHIFT];
endmodule
`default_nettype wire

// ===== dprm_core_props.sv
// checker for realign sequencing, bandwidth clamps and input limits
// assumes a bind onto dprm_core, everything on clk
`timescale 1ns/1ps
`default_nettype none
module dprm_core_props #(
	parameter NIN       = 14,
	parameter RAMP_STEP = 16,
	parameter DIV_CYC   = 8
) (
	input wire logic               clk,
	input wire logic               reset_n,
	input wire logic [7:0]         addr,
	input wire logic [7:0]         wdata,
	input wire logic               wstrobe,
	input wire logic               mini_holdover,
	input wire logic               divider_reset,
	input wire logic signed [16:0] applied_offset,
	input wire logic               secondary_path_disable,
	input wire logic [4:0]         primary_bandwidth,
	input wire logic [1:0]         secondary_bandwidth,
	input wire logic [NIN*8-1:0]   input_loop_frequency_readout_offset,
	input wire logic [NIN-1:0]     input_invalid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [7:0]  dcnt;
	logic [15:0] tgt;
	logic [7:0]  lim;
	logic [7:0]  o0;
	logic [8:0]  mag;
	// magnitude of monitor zero, signed byte
	assign o0 = input_loop_frequency_readout_offset[7:0];
	assign mag = o0[7] ? (9'h100 - {1'b0, o0}) : {1'b0, o0};
	// mirror of offset target, limit and divider pulse length
	always @(posedge clk) begin
		if (!reset_n) begin
			dcnt <= 8'h00;
			tgt <= 16'h0000;
			lim <= 8'h20;
		end else begin
			dcnt <= divider_reset ? dcnt + 8'h01 : 8'h00;
			if (wstrobe && addr == 8'h04) tgt[7:0] <= wdata;
			if (wstrobe && addr == 8'h05) tgt[15:8] <= wdata;
			if (wstrobe && addr == 8'h08) lim <= wdata;
		end
	end
	sequence s_request;
		wstrobe && addr == 8'h00 && wdata[0] && !mini_holdover;
	endsequence
	sequence s_enter;
		##[1:4] mini_holdover;
	endsequence
	a_holdover_start: assert property (s_request |-> s_enter)
		else $error("holdover did not follow request");
	a_divreset_in_hold: assert property (divider_reset |-> mini_holdover)
		else $error("divider reset outside holdover");
	a_offset_zero_div: assert property (divider_reset |-> applied_offset == 17'sh00000)
		else $error("offset not zero at divider reset");
	a_divreset_length: assert property ($fell(divider_reset) |-> dcnt == DIV_CYC)
		else $error("divider reset length wrong");
	a_ramp_step_size: assert property (mini_holdover && $past(mini_holdover) |->
		($past(applied_offset) - applied_offset <= RAMP_STEP) &&
		(applied_offset - $past(applied_offset) <= RAMP_STEP))
		else $error("offset ramp step too large");
	a_final_target: assert property ($fell(mini_holdover) |-> applied_offset == $signed(tgt))
		else $error("ramp did not end at offset target");
	a_compare_disable: assert property (wstrobe && addr == 8'h02 && wdata[0] |->
		##[1:2] secondary_path_disable)
		else $error("secondary path not disabled");
	a_bw_clamp_range: assert property (primary_bandwidth <= 5'h11 && secondary_bandwidth <= 2'h2)
		else $error("bandwidth setting out of range");
	a_invalid_limit: assert property ($past(reset_n) && !$past(wstrobe) && !$past(wstrobe, 2) &&
		$stable(o0) |-> input_invalid[0] == (mag > {1'b0, lim}))
		else $error("input invalid flag disagrees with limit");
endmodule
`default_nettype wire

// ===== dprm_ref_model.sv
// loop and monitor values seen from the reference side
// assumes values change only when the bench flips mode
`timescale 1ns/1ps
`default_nettype none
module dprm_ref_model (
	input wire logic                clk,
	input wire logic                mode,
	output wire logic signed [23:0] primary_integral,
	output wire logic signed [23:0] secondary_integral,
	output wire logic signed [15:0] primary_pd_error,
	output wire logic signed [15:0] secondary_pd_error,
	output wire logic signed [15:0] primary_ref_phase,
	output wire logic signed [15:0] secondary_ref_phase,
	output wire logic [3:0]         secondary_auto_select,
	output wire logic [111:0]       input_loop_frequency_readout_offset
);
	logic mode_q = 1'b0;
	// mode taken on the clock, so the loop value moves on an edge
	always @(posedge clk) mode_q <= mode;
	// mode 1 pushes the primary loop beyond its readout range
	assign primary_integral = mode_q ? 24'sh400000 : 24'sh012345;
	assign secondary_integral = 24'shFEDCBA;
	assign primary_pd_error = 16'sh0040;
	assign secondary_pd_error = 16'sh0020;
	assign primary_ref_phase = 16'sh0100;
	assign secondary_ref_phase = 16'sh0080;
	// selector choice when nothing is forced
	assign secondary_auto_select = 4'h3;
	// monitor zero at -40 counts, monitor one at +16
	assign input_loop_frequency_readout_offset = {96'h0, 8'h10, 8'hD8};
endmodule
`default_nettype wire

// ===== dprm_core_tb.sv
// self-checking bench for dprm_core with the reference model beside it
// assumes register port, loop values and monitors all on clk
`timescale 1ns/1ps
`default_nettype none
`include "dprm_defs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module dprm_core_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wstrobe = 1'b0;
	logic rstrobe = 1'b0;
	logic mode = 1'b0;
	wire [7:0] rdata;
	wire signed [23:0] pri_int, sec_int;
	wire signed [15:0] pri_pd, sec_pd, pri_ph, sec_ph;
	wire [3:0] auto_sel, sec_sel;
	wire [111:0] loop_frequency_readout_ofs;
	wire hold, div_rst, sec_dis, copy_div, copy_by_n;
	wire signed [16:0] ofs;
	wire [1:0] lock_mode, sec_bw;
	wire [4:0] pri_bw;
	wire [13:0] invalid;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	// free running system clock
	always #5 clk = ~clk;
	dprm_ref_model i_dprm_ref_model (.clk(clk), .mode(mode), .primary_integral(pri_int),
		.secondary_integral(sec_int), .primary_pd_error(pri_pd), .secondary_pd_error(sec_pd),
		.primary_ref_phase(pri_ph), .secondary_ref_phase(sec_ph),
		.secondary_auto_select(auto_sel), .input_loop_frequency_readout_offset(loop_frequency_readout_ofs));
	dprm_core #(.NIN(14), .RAMP_STEP(16), .DIV_CYC(8)) i_dprm_core (.clk(clk),
		.reset_n(reset_n), .addr(addr), .wdata(wdata), .wstrobe(wstrobe), .rstrobe(rstrobe),
		.rdata(rdata), .primary_integral(pri_int), .secondary_integral(sec_int),
		.primary_pd_error(pri_pd), .secondary_pd_error(sec_pd), .primary_ref_phase(pri_ph),
		.secondary_ref_phase(sec_ph), .secondary_auto_select(auto_sel),
		.input_loop_frequency_readout_offset(loop_frequency_readout_ofs), .mini_holdover(hold), .divider_reset(div_rst),
		.applied_offset(ofs), .secondary_path_disable(sec_dis), .secondary_select(sec_sel),
		.copy_divide(copy_div), .copy_by_n(copy_by_n), .primary_lock_mode(lock_mode),
		.primary_bandwidth(pri_bw), .secondary_bandwidth(sec_bw), .input_invalid(invalid));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wstrobe <= 1'b1;
		@(posedge clk);
		wstrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rstrobe <= 1'b1;
		@(posedge clk);
		rstrobe <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic t_bw();
		logic [7:0] d;
		rd(`DPRM_ADDR_BW, d);
		`CHK("bw reset", 8'h0A, d)
		rd(8'h30, d);
		`CHK("unmapped", 8'h00, d)
		wr(`DPRM_ADDR_BW, 8'h7F);
		settle();
		`CHK("pri bw", 5'h11, pri_bw)
		`CHK("sec bw", 2'h2, sec_bw)
		wr(`DPRM_ADDR_BW, 8'h2A);
		settle();
		`CHK("pri bw", 5'h0A, pri_bw)
		`CHK("sec bw", 2'h1, sec_bw)
	endtask
	task automatic t_loop_frequency_readout();
		logic [7:0] d0, d1, d2;
		wr(`DPRM_ADDR_MC11, 8'h00);
		rd(`DPRM_ADDR_FRQ1, d0);
		mode <= 1'b1;
		rd(`DPRM_ADDR_FRQ2, d1);
		rd(`DPRM_ADDR_FRQ3, d2);
		`CHK("loop_frequency_readout pri", 24'h012345, {d2, d1, d0})
		rd(`DPRM_ADDR_FRQ1, d0);
		rd(`DPRM_ADDR_FRQ2, d1);
		rd(`DPRM_ADDR_FRQ3, d2);
		`CHK("loop_frequency_readout clamp", `DPRM_FRQ_MAX, {d2, d1, d0})
		wr(`DPRM_ADDR_MC11, 8'h01);
		rd(`DPRM_ADDR_FRQ1, d0);
		rd(`DPRM_ADDR_FRQ2, d1);
		rd(`DPRM_ADDR_FRQ3, d2);
		`CHK("loop_frequency_readout sec", 24'hFEDCBA, {d2, d1, d0})
	endtask
	task automatic t_realign();
		logic [7:0] d;
		int n;
		int nd;
		wr(`DPRM_ADDR_OFS_LO, 8'h40);
		wr(`DPRM_ADDR_OFS_HI, 8'h00);
		settle();
		`CHK("offset", 17'sh00040, ofs)
		wr(`DPRM_ADDR_FSC3, 8'h01);
		n = 0;
		while (hold !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK("holdover", 1'b1, hold)
		wr(`DPRM_ADDR_OFS_LO, 8'h20);
		nd = 0;
		while (hold !== 1'b0 && n < 500) begin
			@(posedge clk);
			#1;
			n++;
			if (div_rst === 1'b1) nd++;
		end
		`CHK("div cycles", 8, nd)
		`CHK("final offset", 17'sh00020, ofs)
		rd(`DPRM_ADDR_FSC3, d);
		`CHK("realign bit", 8'h00, d)
	endtask
	task automatic t_compare();
		logic [1:0] s;
		logic [1:0] p;
		// every secondary mode against every primary mode covers the mixed-rate setup
		for (s = 2'h0; s < 2'h3; s++) begin
			for (p = 2'h0; p < 2'h3; p++) begin
				wr(`DPRM_ADDR_ICFG, {4'h0, s, p});
				wr(`DPRM_ADDR_PLC1, 8'h01);
				settle();
				`CHK("sec disable", 1'b1, sec_dis)
				`CHK("copy divide", (s != 2'h0), copy_div)
				`CHK("copy by n", (p == 2'h2), copy_by_n)
				`CHK("pri mode", p, lock_mode)
			end
		end
		wr(`DPRM_ADDR_PLC1, 8'h00);
		settle();
		`CHK("sec disable", 1'b0, sec_dis)
	endtask
	task automatic t_force_limit();
		wr(`DPRM_ADDR_MC4, 8'h05);
		settle();
		`CHK("forced sel", 4'h5, sec_sel)
		wr(`DPRM_ADDR_MC4, 8'h00);
		settle();
		`CHK("auto sel", 4'h3, sec_sel)
		`CHK("invalid", 14'h0001, invalid)
		wr(`DPRM_ADDR_ILIM, 8'h30);
		settle();
		`CHK("invalid", 14'h0000, invalid)
	endtask
	// averaged phase per loop: reference compare feeds the secondary a larger error
	task automatic t_phase();
		logic [7:0] d0, d1;
		logic signed [15:0] pri;
		wr(`DPRM_ADDR_PLC1, 8'h01);
		repeat (8000) @(posedge clk);
		wr(`DPRM_ADDR_MC11, 8'h00);
		rd(`DPRM_ADDR_PHS1, d0);
		rd(`DPRM_ADDR_PHS2, d1);
		pri = {d1, d0};
		`CHK("phase pri", 1'b1, (pri > 16'sh0000 && pri <= 16'sh0040))
		wr(`DPRM_ADDR_MC11, 8'h01);
		rd(`DPRM_ADDR_PHS1, d0);
		rd(`DPRM_ADDR_PHS2, d1);
		`CHK("phase sec", 1'b1, ($signed({d1, d0}) > pri && {d1, d0} <= 16'h0080))
		rd(`DPRM_ADDR_STAT, d0);
		`CHK("status", 8'h0C, d0)
	endtask
	// cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		t_bw();
		t_loop_frequency_readout();
		t_realign();
		t_compare();
		t_force_limit();
		t_phase();
		finish_test();
	end
endmodule
bind dprm_core dprm_core_props #(.NIN(NIN), .RAMP_STEP(RAMP_STEP), .DIV_CYC(DIV_CYC)) i_props (
	.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wstrobe(wstrobe),
	.mini_holdover(mini_holdover), .divider_reset(divider_reset),
	.applied_offset(applied_offset), .secondary_path_disable(secondary_path_disable),
	.primary_bandwidth(primary_bandwidth), .secondary_bandwidth(secondary_bandwidth),
	.input_loop_frequency_readout_offset(input_loop_frequency_readout_offset), .input_invalid(input_invalid));
`default_nettype wire
